/* design/rncp_consts.svh */
// constants for the radio network configuration parameter bank
`ifndef RNCP_CONSTS_SVH
`define RNCP_CONSTS_SVH
`define RNCP_SEL_COMPAT      3'h0
`define RNCP_SEL_FREQ_INDEX  3'h1
`define RNCP_SEL_NET_TAG     3'h2
`define RNCP_SEL_DEST_HI     3'h3
`define RNCP_SEL_DEST_LO     3'h4
`define RNCP_RST_COMPAT      2'h0
`define RNCP_RST_FREQ_INDEX  8'h0C
`define RNCP_RST_NET_TAG     16'h3332
`define RNCP_RST_DEST_HI     32'h00000000
`define RNCP_RST_DEST_LO     32'h00000000
`define RNCP_COMPAT_TX_BIT   0
`define RNCP_COMPAT_DS_BIT   1
`define RNCP_FREQ_MIN        8'h0B
`define RNCP_FREQ_MAX        8'h1A
`define RNCP_FREQ_BASE_MHZ   12'h965
`define RNCP_FREQ_STEP_MHZ   12'h005
`define RNCP_NET_TAG_GLOBAL  16'hFFFF
`define RNCP_SHORT_LIMIT     32'h0000FFFF
`define RNCP_PAYLOAD_BEST    7'h74
`define RNCP_PAYLOAD_LEG_ENC 7'h5F
`define RNCP_PAYLOAD_LEG_CLR 7'h64
`define RNCP_COST_HDR        7'h04
`define RNCP_COST_LONG_SRC   7'h06
`define RNCP_COST_LONG_DST   7'h06
`define RNCP_COST_ENC        7'h12
`define RNCP_DS_TIMEOUT_MS   2500
`define RNCP_CLOCK_MHZ       100
`define RNCP_DS_CYCLES       (`RNCP_DS_TIMEOUT_MS * 1000 * `RNCP_CLOCK_MHZ)
`endif

/* design/rncp_pkg.sv */
// types for the radio network configuration parameter bank
package rncp_pkg;
    typedef enum logic [1:0] {
        RNCP_DS_IDLE = 2'b00,
        RNCP_DS_WAIT = 2'b01,
        RNCP_DS_DONE = 2'b11
    } rncp_ds_state_t;
endpackage : rncp_pkg

/* design/rncp_sync.sv */
// three-stage input synchroniser
`timescale 1ns/1ps
module rncp_sync (
    input  wire logic i_clock,
    input  wire logic i_resetn,
    input  wire logic i_async,
    output logic      o_level
);
    logic [2:0] sync_q;

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            sync_q <= 3'h0;
        end else begin
            sync_q <= {sync_q[1:0], i_async};
        end
    end

    // level changes only once stages two and three agree
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_level <= 1'b0;
        end else if (sync_q[1] == sync_q[2]) begin
            o_level <= sync_q[2];
        end
    end
endmodule : rncp_sync

/* design/rncp_tx_queue.sv */
// transmit slot gate: one slot in legacy mode, several otherwise
`timescale 1ns/1ps
module rncp_tx_queue #(
    parameter int SLOTS = 4
) (
    input  wire logic i_clock,
    input  wire logic i_resetn,
    input  wire logic i_single,
    input  wire logic i_start,
    input  wire logic i_dest_busy,
    input  wire logic i_done,
    output logic      o_grant,
    output logic      o_busy
);
    localparam int CW = $clog2(SLOTS + 1);
    logic [CW-1:0] active_q;
    logic          ok;

    always_comb begin
        ok = i_single ? (active_q == '0)
                      : ((active_q < CW'(SLOTS)) && !i_dest_busy);
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            active_q <= '0;
            o_grant  <= 1'b0;
        end else begin
            o_grant <= i_start && ok;
            if ((i_start && ok) && !(i_done && active_q != '0)) begin
                active_q <= active_q + CW'(1);
            end else if (!(i_start && ok) && i_done && active_q != '0) begin
                active_q <= active_q - CW'(1);
            end
        end
    end

    always_comb begin
        o_busy = (active_q != '0);
    end
endmodule : rncp_tx_queue

/* design/rncp_bank.sv */
// radio network configuration parameter bank
//
// Functional notes
// - bit0 clear: payload limit from header, addresses, encryption; best 116.
// - bit0 clear: several messages active if destinations differ.
// - bit0 set: cap 95 encrypted, 100 clear, never enlarged.
// - bit0 set: one outgoing message active at once.
// - bit1 clear: directed discovery ends at the matching reply.
// - bit1 clear: no reply before timeout reports an error.
// - bit1 set: discovery runs full timeout, other commands refused.
// - bit1 set: at timeout end quietly with success.
// - compat field two bits, read/write, resets to zero.
// - centre frequency 2405 MHz plus 5 MHz per channel above 11.
// - channel 0x0B..0x1A, resets 0x0C; exchange only on match.
// - network tag 16 bits, resets 0x3332; peers must share it.
// - tag 0xFFFF transmits to all networks, receive still filtered.
// - dest high holds upper 32 bits for transparent and sample sends.
// - short addressing when dest high zero and dest low below 0xFFFF.
// - destination 0xFFFF is broadcast and end-device polling address.
// - written values stay pending until apply.
// - dest low holds lower 32 bits of the destination.
`timescale 1ns/1ps
`include "rncp_consts.svh"
module rncp_bank
    import rncp_pkg::*;
#(
    parameter int DS_CYCLES = `RNCP_DS_CYCLES,
    parameter int TX_SLOTS  = 4
) (
    input  wire logic        i_clock,
    input  wire logic        i_resetn,
    // command port
    input  wire logic        i_cmd_wr,
    input  wire logic        i_cmd_rd,
    input  wire logic [2:0]  i_cmd_sel,
    input  wire logic [31:0] i_cmd_wdata,
    input  wire logic        i_cmd_apply,
    output logic [31:0]      o_cmd_rdata,
    output logic             o_cmd_ack,
    output logic             o_cmd_err,
    output logic             o_cmd_busy,
    // directed discovery
    input  wire logic        i_ds_start,
    input  wire logic        i_ds_reply,
    output logic             o_ds_done,
    output logic             o_ds_ok,
    // transmit framing inputs
    input  wire logic        i_hdr_en,
    input  wire logic        i_src_long,
    input  wire logic        i_encrypt_en,
    input  wire logic        i_tx_start,
    input  wire logic        i_tx_dest_busy,
    input  wire logic        i_tx_done,
    output logic             o_tx_grant,
    output logic             o_tx_busy,
    output logic [6:0]       o_payload_max,
    // radio side
    input  wire logic [7:0]  i_rx_freq_index,
    input  wire logic [15:0] i_rx_network_tag,
    output logic [11:0]      o_freq_mhz,
    output logic             o_rx_match,
    output logic             o_tx_all_networks,
    output logic             o_dest_short,
    output logic             o_dest_bcast,
    output logic [1:0]       o_compat_ctrl,
    output logic [7:0]       o_radio_freq_index,
    output logic [15:0]      o_network_tag,
    output logic [31:0]      o_dest_addr_hi,
    output logic [31:0]      o_dest_addr_lo
);
    ////////////////////////////////////////////////////////////////////////
    // pending and active parameter copies
    logic [1:0]  p_compat_q, compat_q;
    logic [7:0]  p_freq_q, freq_q;
    logic [15:0] p_tag_q, tag_q;
    logic [31:0] p_hi_q, p_lo_q;
    logic        range_ok;
    logic        ds_refuse;

    always_comb begin
        unique case (i_cmd_sel)
            `RNCP_SEL_COMPAT:     range_ok = (i_cmd_wdata[31:2] == '0);
            `RNCP_SEL_FREQ_INDEX: range_ok = (i_cmd_wdata[31:8] == '0)
                && (i_cmd_wdata[7:0] >= `RNCP_FREQ_MIN)
                && (i_cmd_wdata[7:0] <= `RNCP_FREQ_MAX);
            `RNCP_SEL_NET_TAG:    range_ok = (i_cmd_wdata[31:16] == '0);
            `RNCP_SEL_DEST_HI,
            `RNCP_SEL_DEST_LO:    range_ok = 1'b1;
            default:              range_ok = 1'b0;
        endcase
    end

    // pending writes; nothing lands while legacy discovery holds the port
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            p_compat_q <= `RNCP_RST_COMPAT;
            p_freq_q   <= `RNCP_RST_FREQ_INDEX;
            p_tag_q    <= `RNCP_RST_NET_TAG;
            p_hi_q     <= `RNCP_RST_DEST_HI;
            p_lo_q     <= `RNCP_RST_DEST_LO;
        end else if (i_cmd_wr && range_ok && !ds_refuse) begin
            unique case (i_cmd_sel)
                `RNCP_SEL_COMPAT:     p_compat_q <= i_cmd_wdata[1:0];
                `RNCP_SEL_FREQ_INDEX: p_freq_q <= i_cmd_wdata[7:0];
                `RNCP_SEL_NET_TAG:    p_tag_q <= i_cmd_wdata[15:0];
                `RNCP_SEL_DEST_HI:    p_hi_q <= i_cmd_wdata;
                `RNCP_SEL_DEST_LO:    p_lo_q <= i_cmd_wdata;
                default: ;
            endcase
        end
    end

    // active copies change only on apply
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            compat_q       <= `RNCP_RST_COMPAT;
            freq_q         <= `RNCP_RST_FREQ_INDEX;
            tag_q          <= `RNCP_RST_NET_TAG;
            o_dest_addr_hi <= `RNCP_RST_DEST_HI;
            o_dest_addr_lo <= `RNCP_RST_DEST_LO;
        end else if (i_cmd_apply && !ds_refuse) begin
            compat_q       <= p_compat_q;
            freq_q         <= p_freq_q;
            tag_q          <= p_tag_q;
            o_dest_addr_hi <= p_hi_q;
            o_dest_addr_lo <= p_lo_q;
        end
    end

    // command answers
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_cmd_ack   <= 1'b0;
            o_cmd_err   <= 1'b0;
            o_cmd_rdata <= 32'h00000000;
        end else begin
            o_cmd_ack <= (i_cmd_wr || i_cmd_rd || i_cmd_apply) && !ds_refuse
                && !(i_cmd_wr && !range_ok)
                && !(i_cmd_rd && i_cmd_sel > 3'h4);
            o_cmd_err <= (i_cmd_wr && !range_ok)
                || (i_cmd_rd && i_cmd_sel > 3'h4)
                || ((i_cmd_wr || i_cmd_rd || i_cmd_apply) && ds_refuse);
            if (i_cmd_rd && !ds_refuse) begin
                unique case (i_cmd_sel)
                    `RNCP_SEL_COMPAT:     o_cmd_rdata <= {30'h0, p_compat_q};
                    `RNCP_SEL_FREQ_INDEX: o_cmd_rdata <= {24'h0, p_freq_q};
                    `RNCP_SEL_NET_TAG:    o_cmd_rdata <= {16'h0, p_tag_q};
                    `RNCP_SEL_DEST_HI:    o_cmd_rdata <= p_hi_q;
                    `RNCP_SEL_DEST_LO:    o_cmd_rdata <= p_lo_q;
                    default:              o_cmd_rdata <= 32'h00000000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // directed discovery
    rncp_ds_state_t ds_q;
    logic [31:0]    ds_cnt_q;
    logic           ds_seen_q;
    logic           ds_legacy_q;
    logic           reply_lvl, reply_d_q, reply_evt;

    // async reply pin
    rncp_sync u_reply_sync (
        .i_clock  (i_clock),
        .i_resetn (i_resetn),
        .i_async  (i_ds_reply),
        .o_level  (reply_lvl)
    );

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            reply_d_q <= 1'b0;
        end else begin
            reply_d_q <= reply_lvl;
        end
    end
    assign reply_evt = reply_lvl && !reply_d_q;
    assign ds_refuse = (ds_q == RNCP_DS_WAIT) && ds_legacy_q;

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            ds_q        <= RNCP_DS_IDLE;
            ds_cnt_q    <= 32'h00000000;
            ds_seen_q   <= 1'b0;
            ds_legacy_q <= 1'b0;
            o_ds_done   <= 1'b0;
            o_ds_ok     <= 1'b0;
        end else begin
            o_ds_done <= 1'b0;
            unique case (ds_q)
                RNCP_DS_IDLE: begin
                    if (i_ds_start) begin
                        ds_q        <= RNCP_DS_WAIT;
                        ds_cnt_q    <= 32'h00000000;
                        ds_seen_q   <= 1'b0;
                        ds_legacy_q <= compat_q[`RNCP_COMPAT_DS_BIT];
                    end
                end
                RNCP_DS_WAIT: begin
                    ds_cnt_q <= ds_cnt_q + 32'h00000001;
                    if (reply_evt) begin
                        ds_seen_q <= 1'b1;
                    end
                    if (reply_evt && !ds_legacy_q) begin
                        ds_q      <= RNCP_DS_DONE;
                        o_ds_done <= 1'b1;
                        o_ds_ok   <= 1'b1;
                    end else if (ds_cnt_q >= 32'(DS_CYCLES - 1)) begin
                        ds_q      <= RNCP_DS_DONE;
                        o_ds_done <= 1'b1;
                        // legacy: success regardless; else error
                        o_ds_ok   <= ds_legacy_q;
                    end
                end
                RNCP_DS_DONE: begin
                    ds_q <= RNCP_DS_IDLE;
                end
                default: ds_q <= RNCP_DS_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_cmd_busy <= 1'b0;
        end else begin
            o_cmd_busy <= ds_refuse;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transmit limits and queue
    logic       dst_long;
    logic [6:0] best;

    assign dst_long = !((o_dest_addr_hi == 32'h0)
        && (o_dest_addr_lo < `RNCP_SHORT_LIMIT));

    always_comb begin
        best = `RNCP_PAYLOAD_BEST;
        if (i_hdr_en) best = best - `RNCP_COST_HDR;
        if (i_src_long) best = best - `RNCP_COST_LONG_SRC;
        if (dst_long) best = best - `RNCP_COST_LONG_DST;
        if (i_encrypt_en) best = best - `RNCP_COST_ENC;
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_payload_max <= `RNCP_PAYLOAD_BEST;
        end else if (compat_q[`RNCP_COMPAT_TX_BIT]) begin
            o_payload_max <= i_encrypt_en ? `RNCP_PAYLOAD_LEG_ENC
                                          : `RNCP_PAYLOAD_LEG_CLR;
        end else begin
            o_payload_max <= best;
        end
    end

    rncp_tx_queue #(.SLOTS(TX_SLOTS)) u_txq (
        .i_clock     (i_clock),
        .i_resetn    (i_resetn),
        .i_single    (compat_q[`RNCP_COMPAT_TX_BIT]),
        .i_start     (i_tx_start),
        .i_dest_busy (i_tx_dest_busy),
        .i_done      (i_tx_done),
        .o_grant     (o_tx_grant),
        .o_busy      (o_tx_busy)
    );

    ////////////////////////////////////////////////////////////////////////
    // radio addressing outputs
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_freq_mhz         <= 12'h000;
            o_rx_match         <= 1'b0;
            o_tx_all_networks  <= 1'b0;
            o_dest_short       <= 1'b0;
            o_dest_bcast       <= 1'b0;
            o_compat_ctrl      <= `RNCP_RST_COMPAT;
            o_radio_freq_index <= `RNCP_RST_FREQ_INDEX;
            o_network_tag      <= `RNCP_RST_NET_TAG;
        end else begin
            o_freq_mhz <= `RNCP_FREQ_BASE_MHZ + 12'(freq_q - `RNCP_FREQ_MIN)
                * `RNCP_FREQ_STEP_MHZ;
            // global tag only widens transmit, never receive
            o_rx_match <= (i_rx_freq_index == freq_q)
                && (i_rx_network_tag == tag_q);
            o_tx_all_networks <= (tag_q == `RNCP_NET_TAG_GLOBAL);
            o_dest_short <= !dst_long;
            o_dest_bcast <= (o_dest_addr_hi == 32'h0)
                && (o_dest_addr_lo == `RNCP_SHORT_LIMIT);
            o_compat_ctrl      <= compat_q;
            o_radio_freq_index <= freq_q;
            o_network_tag      <= tag_q;
        end
    end
endmodule : rncp_bank

/* verif/rncp_bank_monitor.sv */
// port checker for the parameter bank
`timescale 1ns/1ps
`include "rncp_consts.svh"
module rncp_bank_monitor (
    input  wire logic        i_clock,
    input  wire logic        i_resetn,
    input  wire logic        i_cmd_wr,
    input  wire logic        i_cmd_rd,
    input  wire logic        i_cmd_apply,
    input  wire logic [2:0]  i_cmd_sel,
    input  wire logic [31:0] i_cmd_wdata,
    input  wire logic        o_cmd_ack,
    input  wire logic        o_cmd_err,
    input  wire logic        o_cmd_busy,
    input  wire logic        o_ds_done,
    input  wire logic        o_ds_ok,
    input  wire logic        i_encrypt_en,
    input  wire logic        i_tx_start,
    input  wire logic        o_tx_grant,
    input  wire logic        o_tx_busy,
    input  wire logic [6:0]  o_payload_max,
    input  wire logic [11:0] o_freq_mhz,
    input  wire logic        o_tx_all_networks,
    input  wire logic [1:0]  o_compat_ctrl,
    input  wire logic [7:0]  o_radio_freq_index,
    input  wire logic [15:0] o_network_tag
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_resetn);
    ////////////////////////////////////////////////////////////////////////
    property p_answer;
        (i_cmd_wr || i_cmd_rd || i_cmd_apply) |=> (o_cmd_ack != o_cmd_err);
    endproperty
    a_answer: assert property (p_answer) else $error("no single answer");
    property p_bad_chan;
        i_cmd_wr && i_cmd_sel == `RNCP_SEL_FREQ_INDEX
            && (i_cmd_wdata < 32'h0000000B || i_cmd_wdata > 32'h0000001A)
            |=> o_cmd_err;
    endproperty
    a_bad_chan: assert property (p_bad_chan) else $error("bad channel kept");
    property p_pending;
        $changed({o_compat_ctrl, o_radio_freq_index, o_network_tag})
            |-> $past(i_cmd_apply) || $past(i_cmd_apply, 2);
    endproperty
    a_pending: assert property (p_pending) else $error("change w/o apply");
    property p_freq_map;
        $past(i_resetn) && $stable(o_radio_freq_index) |-> o_freq_mhz ==
            `RNCP_FREQ_BASE_MHZ + `RNCP_FREQ_STEP_MHZ
            * ({4'h0, o_radio_freq_index} - 12'h00B);
    endproperty
    a_freq_map: assert property (p_freq_map) else $error("bad frequency");
    property p_tx_all;
        $past(i_resetn) && $stable(o_network_tag) |->
            o_tx_all_networks == (o_network_tag == `RNCP_NET_TAG_GLOBAL);
    endproperty
    a_tx_all: assert property (p_tx_all) else $error("bad global flag");
    property p_single;
        o_compat_ctrl[0] && o_tx_busy && i_tx_start |=> !o_tx_grant;
    endproperty
    a_single: assert property (p_single) else $error("second message");
    property p_ds_refuse;
        o_cmd_busy && (i_cmd_wr || i_cmd_rd || i_cmd_apply)
            |=> o_cmd_err && !o_cmd_ack;
    endproperty
    a_ds_refuse: assert property (p_ds_refuse) else $error("taken in wait");
    property p_ds_ok;
        o_ds_done && o_compat_ctrl[1] |-> o_ds_ok;
    endproperty
    a_ds_ok: assert property (p_ds_ok) else $error("legacy not ok");
    property p_legacy_pay;
        o_compat_ctrl[0] && $stable(o_compat_ctrl) && $past(i_resetn)
            && i_encrypt_en == $past(i_encrypt_en)
            && i_encrypt_en == $past(i_encrypt_en, 2) |-> o_payload_max ==
            (i_encrypt_en ? `RNCP_PAYLOAD_LEG_ENC : `RNCP_PAYLOAD_LEG_CLR);
    endproperty
    a_legacy_pay: assert property (p_legacy_pay) else $error("bad cap");
    ////////////////////////////////////////////////////////////////////////
    c_legacy_ds: cover property (o_ds_done && o_compat_ctrl[1]);
    c_refused: cover property (o_cmd_err);
    c_blocked: cover property (o_compat_ctrl[0] && o_tx_busy && i_tx_start);
endmodule : rncp_bank_monitor

bind rncp_bank rncp_bank_monitor rncp_bank_monitor_inst (.*);

/* verif/rncp_host_model.sv */
// host model issuing configuration commands
`timescale 1ns/1ps
module rncp_host_model (
    input  wire logic        i_clock,
    input  wire logic [31:0] i_cmd_rdata,
    input  wire logic        i_cmd_ack,
    input  wire logic        i_cmd_err,
    output logic             o_cmd_wr,
    output logic             o_cmd_rd,
    output logic             o_cmd_apply,
    output logic [2:0]       o_cmd_sel,
    output logic [31:0]      o_cmd_wdata
);
    initial begin
        {o_cmd_wr, o_cmd_rd, o_cmd_apply} = 3'h0;
        o_cmd_sel   = 3'h0;
        o_cmd_wdata = 32'h0;
    end
    // kind 0 write, 1 read, 2 apply
    task automatic cmd(input logic [1:0] k, input logic [2:0] s,
                       input logic [31:0] d, output logic a,
                       output logic e, output logic [31:0] r);
        @(posedge i_clock);
        #1;
        {o_cmd_apply, o_cmd_rd, o_cmd_wr} = {k == 2'h2, k == 2'h1, k == 2'h0};
        o_cmd_sel   = s;
        o_cmd_wdata = d;
        @(posedge i_clock);
        #1;
        {o_cmd_wr, o_cmd_rd, o_cmd_apply} = 3'h0;
        // released lines flip so stale values never look valid
        o_cmd_sel   = ~s;
        o_cmd_wdata = ~d;
        a = i_cmd_ack;
        e = i_cmd_err;
        r = i_cmd_rdata;
    endtask : cmd
endmodule : rncp_host_model

/* verif/tb_rncp_bank.sv */
// self-checking bench for the parameter bank
`timescale 1ns/1ps
`include "rncp_consts.svh"
module tb_rncp_bank;
    localparam int DS = 50;
    logic        i_clock, i_resetn, i_cmd_wr, i_cmd_rd, i_cmd_apply;
    logic [2:0]  i_cmd_sel;
    logic [31:0] i_cmd_wdata, o_cmd_rdata, o_dest_addr_hi, o_dest_addr_lo;
    logic        o_cmd_ack, o_cmd_err, o_cmd_busy, i_ds_start, i_ds_reply;
    logic        o_ds_done, o_ds_ok, i_hdr_en, i_src_long, i_encrypt_en;
    logic        i_tx_start, i_tx_dest_busy, i_tx_done, o_tx_grant, o_tx_busy;
    logic        o_tx_all_networks, o_dest_short, o_dest_bcast, o_rx_match;
    logic [6:0]  o_payload_max;
    logic [7:0]  i_rx_freq_index, o_radio_freq_index, cn, pcn;
    logic [15:0] i_rx_network_tag, o_network_tag;
    logic [11:0] o_freq_mhz;
    logic [1:0]  o_compat_ctrl;
    logic [31:0] r, w, hi, lo, rng;
    int          error_cnt, comparisons, el;
    rncp_bank #(.DS_CYCLES(DS), .TX_SLOTS(4)) rncp_bank_inst (.*);
    rncp_host_model rncp_host_model_inst (.i_clock, .i_cmd_rdata(o_cmd_rdata),
        .i_cmd_ack(o_cmd_ack), .i_cmd_err(o_cmd_err), .o_cmd_wr(i_cmd_wr),
        .o_cmd_rd(i_cmd_rd), .o_cmd_apply(i_cmd_apply), .o_cmd_sel(i_cmd_sel),
        .o_cmd_wdata(i_cmd_wdata));
    always #5 i_clock = ~i_clock;
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction : xs
    function automatic logic [11:0] freq_exp(input logic [7:0] c);
        return 12'h965 + 12'h005 * ({4'h0, c} - 12'h00B);
    endfunction : freq_exp
    // f: legacy, long dest, header, long source, encrypt
    function automatic logic [6:0] pay_exp(input logic [4:0] f);
        if (f[4]) return f[0] ? 7'h5F : 7'h64;
        return 7'h74 - (f[3] ? 7'h06 : 7'h00) - (f[2] ? 7'h04 : 7'h00)
            - (f[1] ? 7'h06 : 7'h00) - (f[0] ? 7'h12 : 7'h00);
    endfunction : pay_exp
    task automatic chk(input logic ok, input string m);
        comparisons++;
        if (!ok) begin
            error_cnt++;
            $display("BAD %0t %s", $time, m);
        end
    endtask : chk
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_sim
    task automatic tick(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask : tick
    task automatic cmd(input logic [1:0] k, input logic [2:0] s,
                       input logic [31:0] d, input logic bad);
        logic a, e;
        rncp_host_model_inst.cmd(k, s, d, a, e, r);
        chk(a === !bad && e === bad, "command answer");
    endtask : cmd
    task automatic rd(input logic [2:0] s, input logic [31:0] x);
        cmd(2'h1, s, 32'h0, 1'b0);
        chk(r === x, "read back");
    endtask : rd
    task automatic set(input logic [2:0] s, input logic [31:0] d);
        cmd(2'h0, s, d, 1'b0);
        cmd(2'h2, 3'h0, 32'h0, 1'b0);
        tick(2);
    endtask : set
    task automatic tx(input logic dn, input logic b, input logic g);
        i_tx_dest_busy = b;
        if (dn) i_tx_done = 1'b1;
        else i_tx_start = 1'b1;
        tick(1);
        {i_tx_start, i_tx_done} = 2'h0;
        if (!dn) chk(o_tx_grant === g, "grant");
        tick(1);
    endtask : tx
    task automatic ds(input logic [1:0] c, input logic rep, input logic ok,
                      input int lo_c, input int hi_c);
        set(`RNCP_SEL_COMPAT, {30'h0, c});
        i_ds_start = 1'b1;
        el = $time;
        tick(1);
        i_ds_start = 1'b0;
        for (int i = 0; i < 100 && o_ds_done !== 1'b1; i++) begin
            if (i == 4) i_ds_reply = rep;
            if (i == 8) chk(o_cmd_busy === c[1], "busy");
            if (i == 8 && c[1]) cmd(2'h1, 3'h0, 32'h0, 1'b1);
            tick(1);
        end
        el = ($time - el) / 10;
        chk(o_ds_done === 1'b1 && o_ds_ok === ok, "discovery status");
        chk(el >= lo_c && el <= hi_c, "discovery time");
        if (o_ds_done !== 1'b1) end_sim();
        i_ds_reply = 1'b0;
        tick(8);
    endtask : ds
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {i_clock, i_resetn, i_ds_start, i_ds_reply, i_hdr_en} = 5'h0;
        {i_src_long, i_encrypt_en, i_tx_start, i_tx_dest_busy, i_tx_done} = 5'h0;
        i_rx_freq_index = 8'h0C;
        i_rx_network_tag = 16'h3332;
        rng = 32'h220D;
        error_cnt = 0;
        comparisons = 0;
        pcn = 8'h0C;
        tick(3);
        i_resetn = 1'b1;
        chk(o_network_tag === 16'h3332 && o_compat_ctrl === 2'h0, "rst");
        rd(`RNCP_SEL_COMPAT, 32'h0);
        rd(`RNCP_SEL_FREQ_INDEX, 32'h0C);
        rd(`RNCP_SEL_NET_TAG, 32'h3332);
        $display("test reset values done");
        for (int n = 0; n < 8; n++) begin
            w = xs();
            cn = (n < 2) ? (n ? 8'h1A : 8'h0B) : 8'h0B + {4'h0, w[3:0]};
            cmd(2'h0, `RNCP_SEL_FREQ_INDEX, {24'h0, cn}, 1'b0);
            cmd(2'h0, `RNCP_SEL_NET_TAG, {16'h0, w[31:16]}, 1'b0);
            cmd(2'h0, `RNCP_SEL_COMPAT, {30'h0, w[5:4]}, 1'b0);
            rd(`RNCP_SEL_FREQ_INDEX, {24'h0, cn});
            chk(o_radio_freq_index === pcn, "applied early");
            cmd(2'h2, 3'h0, 32'h0, 1'b0);
            tick(2);
            chk(o_freq_mhz === freq_exp(cn), "frequency");
            chk(o_network_tag === w[31:16] && o_compat_ctrl === w[5:4], "ap");
            pcn = cn;
        end
        cmd(2'h0, `RNCP_SEL_FREQ_INDEX, 32'h0A, 1'b1);
        cmd(2'h0, `RNCP_SEL_FREQ_INDEX, 32'h1B, 1'b1);
        cmd(2'h0, `RNCP_SEL_COMPAT, 32'h4, 1'b1);
        cmd(2'h0, `RNCP_SEL_NET_TAG, 32'h10000, 1'b1);
        cmd(2'h0, 3'h5, 32'h0, 1'b1);
        rd(`RNCP_SEL_FREQ_INDEX, {24'h0, pcn});
        rd(`RNCP_SEL_NET_TAG, {16'h0, w[31:16]});
        $display("test parameter writes done");
        for (int n = 0; n < 6; n++) begin
            hi = (n == 3) ? 32'h1 : 32'h0;
            lo = (n < 3) ? (n ? 32'hFFFE + n - 1 : 32'h1) : 32'hFFFF + n - 3;
            if (n == 5) {hi, lo} = {xs(), xs()};
            cmd(2'h0, `RNCP_SEL_DEST_HI, hi, 1'b0);
            set(`RNCP_SEL_DEST_LO, lo);
            chk(o_dest_addr_hi === hi && o_dest_addr_lo === lo, "dest");
            chk(o_dest_short === (hi == 0 && lo < 32'hFFFF), "short");
            chk(o_dest_bcast === (hi == 0 && lo == 32'hFFFF), "bcast");
        end
        set(`RNCP_SEL_DEST_HI, 32'h0);
        for (int f = 0; f < 32; f++) begin
            if (f[2:0] == 3'h0) begin
                set(`RNCP_SEL_COMPAT, {31'h0, f[4]});
                set(`RNCP_SEL_DEST_LO, f[3] ? 32'h10000 : 32'h1);
            end
            {i_hdr_en, i_src_long, i_encrypt_en} = f[2:0];
            tick(3);
            chk(o_payload_max === pay_exp(f[4:0]), "payload");
        end
        $display("test destination and payload done");
        set(`RNCP_SEL_COMPAT, 32'h1);
        tx(1'b0, 1'b0, 1'b1);
        tx(1'b0, 1'b0, 1'b0);
        tx(1'b1, 1'b0, 1'b0);
        set(`RNCP_SEL_COMPAT, 32'h0);
        repeat (4) tx(1'b0, 1'b0, 1'b1);
        tx(1'b0, 1'b0, 1'b0);
        tx(1'b1, 1'b0, 1'b0);
        tx(1'b0, 1'b1, 1'b0);
        repeat (3) tx(1'b1, 1'b0, 1'b0);
        $display("test transmit queue done");
        ds(2'h0, 1'b1, 1'b1, 1, 20);
        rd(`RNCP_SEL_COMPAT, 32'h0);
        ds(2'h0, 1'b0, 1'b0, DS - 5, DS + 6);
        ds(2'h2, 1'b1, 1'b1, DS - 5, DS + 6);
        ds(2'h2, 1'b0, 1'b1, DS - 5, DS + 6);
        $display("test discovery done");
        set(`RNCP_SEL_COMPAT, 32'h0);
        set(`RNCP_SEL_FREQ_INDEX, 32'h14);
        set(`RNCP_SEL_NET_TAG, 32'h1234);
        for (int n = 0; n < 4; n++) begin
            i_rx_freq_index = n[0] ? 8'h15 : 8'h14;
            i_rx_network_tag = n[1] ? 16'h1235 : 16'h1234;
            tick(2);
            chk(o_rx_match === (n == 0), "match");
        end
        set(`RNCP_SEL_NET_TAG, 32'hFFFF);
        chk(o_tx_all_networks === 1'b1, "global send");
        chk(o_rx_match === 1'b0, "global receive");
        $display("test network match done");
        end_sim();
    end
endmodule : tb_rncp_bank
